/* File: hw/seq_pkg.sv */
package seq_pkg;

  localparam int NUM_VP = 8;
  localparam int VP_W = 3;
  localparam int APB_AW = 12;

  // instruction word layout
  localparam int F_OP_HI = 31;
  localparam int F_OP_LO = 24;
  localparam int F_T_IND = 19;
  localparam int F_T_REG = 18;
  localparam int F_T_PCREL = 17;
  localparam int F_N_HI = 15;
  localparam int F_N_LO = 0;
  localparam int F_SRC_HI = 5;
  localparam int F_SRC_LO = 0;
  localparam int F_DST_HI = 11;
  localparam int F_DST_LO = 6;

  // opcodes
  localparam logic [7:0] OP_NOOP = 8'h00;
  localparam logic [7:0] OP_LEA = 8'h21;
  localparam logic [7:0] OP_EXECUTE_MEMORY_OP = 8'h30;
  localparam logic [7:0] OP_STCR = 8'h41;
  localparam logic [3:0] CBR_GROUP = 4'h5;

  // state class and step codes
  localparam logic [2:0] CLS_EXEC = 3'h1;
  localparam logic [2:0] STEP_EXEC = 3'h1;
  localparam logic [2:0] CLS_LEA = 3'h7;
  localparam logic [2:0] STEP_LEA = 3'h2;
  localparam logic [2:0] CLS_TWO = 3'h2;
  localparam logic [2:0] CLS_THREE = 3'h3;
  localparam logic [2:0] STEP_ONE = 3'h1;
  localparam logic [2:0] STEP_TWO = 3'h2;
  localparam logic [2:0] STEP_THREE = 3'h3;

  // interrupt vectors and program counter moves
  localparam logic [15:0] VEC_AUTO = 16'h0010;
  localparam logic [15:0] VEC_PROG = 16'h0011;
  localparam logic [15:0] PC_STEP = 16'h0001;
  localparam logic [15:0] PC_BACK = 16'h0002;

  // register map
  localparam logic [APB_AW-1:0] OFF_CTRL = 12'h000;
  localparam logic [APB_AW-1:0] OFF_VPSEL = 12'h004;
  localparam logic [APB_AW-1:0] OFF_STATUS = 12'h008;
  localparam logic [APB_AW-1:0] OFF_PC = 12'h00C;
  localparam logic [APB_AW-1:0] OFF_IR = 12'h010;
  localparam int CTRL_RUN_BIT = 0;
  localparam logic RUN_RESET = 1'b1;
  localparam int ST_STEP_LO = 0;
  localparam int ST_CLS_LO = 4;
  localparam int ST_PEND_BIT = 8;
  localparam int ST_MSRC_BIT = 9;
  localparam int ST_INT_BIT = 10;
  localparam int ST_ROM_BIT = 11;

  typedef struct packed {
    logic [2:0] state_class;
    logic [2:0] step;
    logic indirect_pending_flag;
    logic memory_source_flag;
    logic interrupt_active_flag;
    logic int_auto;
    logic rom_origin;
    logic cell_in_register_flag;
    logic [31:0] instruction_register;
    logic [15:0] ea;
    logic [15:0] pc;
    logic [31:0] next_instruction_hold;
  } vp_ctx_type;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [APB_AW-1:0] paddr;
    logic [31:0] pwdata;
  } apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_type;

  typedef struct packed {
    logic valid;
    logic [VP_W-1:0] vp;
    logic buffer_avail;
    logic [31:0] buffer_data;
    logic instruction_done_signal;
    logic dependency;
    logic ignore_indirection;
    logic auto_int;
    logic prog_int;
  } slot_type;

  typedef struct packed {
    logic [VP_W-1:0] vp;
    logic read_req;
    logic [15:0] read_addr;
    logic bd_copy;
    logic [5:0] reg_sel;
  } buf_cmd_type;

  typedef struct packed {
    logic advance;
    logic from_buffer;
    logic [VP_W-1:0] vp;
  } pipe_evt_type;

  function automatic logic [5:0] start_state(input logic [7:0] op);
    if (op == OP_LEA) begin
      start_state = {CLS_LEA, STEP_LEA};
    end else begin
      start_state = {CLS_EXEC, STEP_EXEC};
    end
  endfunction

endpackage

/* File: hw/cell_indexer.sv */
`timescale 1ns/1ps
`default_nettype none
module cell_indexer import seq_pkg::*; (
  input wire logic [31:0] cell_i,
  input wire logic [15:0] pc_i,
  output logic [15:0] ea_o,
  output logic [5:0] src_o,
  output logic [5:0] dst_o
);
  logic [15:0] base;

  // pc-relative cells add the program counter
  assign base = cell_i[F_T_PCREL] ? pc_i : 16'h0000;
  assign ea_o = cell_i[F_N_HI:F_N_LO] + base;
  assign src_o = cell_i[F_SRC_HI:F_SRC_LO];
  assign dst_o = cell_i[F_DST_HI:F_DST_LO];
endmodule
`default_nettype wire

/* File: hw/indirect_and_interrupt_sequencer.sv */
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - rom lea without dependency uses rom advance
// - memory lea step two advances from buffer
// - indirect only after termination, t bit set
// - branches and ignore-indirect instructions bypass indirect
// - non-indirect next: clear pending, source flag copied from rom origin
// - indirect next: set pending, class two step one
// - memory cell: address out, save, read request
// - register cell: save, copy register to buffer
// - communication cell uses source or store destination
// - second step waits buffer only for memory
// - further level: pending set, back to two/one
// - final level clears pending, instruction starts
// - rom instructions without indirect set source flag
// - rom indirect: no save, no flag set
// - memory no-op waits buffer, advances from buffer
// - rom no-op advances without buffer wait
// - vector 10 hex automatic, 11 hex programmed
// - no interrupt at termination: normal advance
// - interrupt entry conditions, flags, no-op, pc+1
// - vector to hold register, pc minus two
// - final interrupt step advances, clears active flag
module indirect_and_interrupt_sequencer import seq_pkg::*; (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire apb_req_type apb_i,
  output var apb_rsp_type apb_o,
  input wire slot_type slot_i,
  output var buf_cmd_type cmd_o,
  output var pipe_evt_type pipe_o
);

  typedef struct packed {
    vp_ctx_type [NUM_VP-1:0] ctx;
    logic run;
    logic [VP_W-1:0] vpsel;
    apb_rsp_type rsp;
    buf_cmd_type cmd;
    pipe_evt_type pipe;
  } top_state_type;

  top_state_type st;
  top_state_type next_st;
  logic [15:0] cell_ea;
  logic [5:0] cell_src;
  logic [5:0] cell_dst;

  cell_indexer indexer (
    .cell_i(slot_i.buffer_data),
    .pc_i(st.ctx[slot_i.vp].pc),
    .ea_o(cell_ea),
    .src_o(cell_src),
    .dst_o(cell_dst)
  );

  assign apb_o = st.rsp;
  assign cmd_o = st.cmd;
  assign pipe_o = st.pipe;

  always_comb begin
    vp_ctx_type c;
    vp_ctx_type s;
    logic term;
    logic from_buf;
    logic clear_int;
    logic [31:0] word;
    c = '0;
    s = st.ctx[st.vpsel];
    term = 1'b0;
    from_buf = 1'b0;
    clear_int = 1'b0;
    word = '0;
    next_st = st;
    next_st.cmd.read_req = 1'b0;
    next_st.cmd.bd_copy = 1'b0;
    next_st.pipe.advance = 1'b0;
    next_st.rsp.pready = 1'b0;
    next_st.rsp.pslverr = 1'b0;
    next_st.rsp.prdata = '0;

    // register access, answered one cycle into the access phase
    if (apb_i.psel && apb_i.penable && !st.rsp.pready) begin
      next_st.rsp.pready = 1'b1;
      unique case (apb_i.paddr)
        OFF_CTRL: begin
          if (apb_i.pwrite) begin
            next_st.run = apb_i.pwdata[CTRL_RUN_BIT];
          end
          next_st.rsp.prdata[CTRL_RUN_BIT] = st.run;
        end
        OFF_VPSEL: begin
          if (apb_i.pwrite) begin
            next_st.vpsel = apb_i.pwdata[VP_W-1:0];
          end
          next_st.rsp.prdata[VP_W-1:0] = st.vpsel;
        end
        OFF_STATUS: begin
          next_st.rsp.prdata[ST_STEP_LO+:3] = s.step;
          next_st.rsp.prdata[ST_CLS_LO+:3] = s.state_class;
          next_st.rsp.prdata[ST_PEND_BIT] = s.indirect_pending_flag;
          next_st.rsp.prdata[ST_MSRC_BIT] = s.memory_source_flag;
          next_st.rsp.prdata[ST_INT_BIT] = s.interrupt_active_flag;
          next_st.rsp.prdata[ST_ROM_BIT] = s.rom_origin;
        end
        OFF_PC: begin
          next_st.rsp.prdata[15:0] = s.pc;
        end
        OFF_IR: begin
          next_st.rsp.prdata = s.instruction_register;
        end
        default: begin
          next_st.rsp.pslverr = 1'b1;
        end
      endcase
    end

    // only the processor owning this slot moves
    if (st.run && slot_i.valid) begin
      c = st.ctx[slot_i.vp];
      unique case ({c.state_class, c.step})
        {CLS_EXEC, STEP_EXEC}: begin
          if (c.instruction_register[F_OP_HI:F_OP_LO] == OP_NOOP) begin
            if (c.rom_origin) begin
              term = 1'b1;
            end else if (slot_i.buffer_avail) begin
              term = 1'b1;
              from_buf = 1'b1;
            end
          end else if (slot_i.instruction_done_signal) begin
            term = 1'b1;
          end
        end
        {CLS_LEA, STEP_LEA}: begin
          if (slot_i.buffer_avail) begin
            if (!slot_i.dependency) begin
              term = 1'b1;
              from_buf = !c.rom_origin;
            end else begin
              c.state_class = CLS_THREE;
              c.step = STEP_TWO;
            end
          end
        end
        {CLS_THREE, STEP_TWO}: begin
          if (c.interrupt_active_flag) begin
            if (slot_i.buffer_avail) begin
              term = 1'b1;
              clear_int = 1'b1;
            end
          end else begin
            term = 1'b1;
            from_buf = !c.rom_origin;
          end
        end
        {CLS_TWO, STEP_THREE}: begin
          c.ea = c.int_auto ? VEC_AUTO : VEC_PROG;
          c.next_instruction_hold = {16'h0000, c.ea};
          c.pc = c.pc - PC_BACK;
          c.state_class = CLS_THREE;
          c.step = STEP_TWO;
        end
        {CLS_TWO, STEP_ONE}: begin
          if (c.cell_in_register_flag) begin
            if (!c.rom_origin) begin
              c.next_instruction_hold = slot_i.buffer_data;
              c.memory_source_flag = 1'b1;
            end
            next_st.cmd.bd_copy = 1'b1;
            next_st.cmd.vp = slot_i.vp;
            if (c.instruction_register[F_OP_HI:F_OP_LO] == OP_STCR) begin
              next_st.cmd.reg_sel = c.instruction_register[F_DST_HI:F_DST_LO];
            end else begin
              next_st.cmd.reg_sel = c.instruction_register[F_SRC_HI:F_SRC_LO];
            end
            c.step = STEP_TWO;
          end else if (slot_i.buffer_avail) begin
            if (!c.rom_origin) begin
              c.next_instruction_hold = slot_i.buffer_data;
              c.memory_source_flag = 1'b1;
            end
            next_st.cmd.read_req = 1'b1;
            next_st.cmd.read_addr = c.ea;
            next_st.cmd.vp = slot_i.vp;
            c.step = STEP_TWO;
          end
        end
        {CLS_TWO, STEP_TWO}: begin
          if (c.cell_in_register_flag || slot_i.buffer_avail) begin
            c.ea = cell_ea;
            c.instruction_register[F_SRC_HI:F_SRC_LO] = cell_src;
            c.instruction_register[F_DST_HI:F_DST_LO] = cell_dst;
            c.cell_in_register_flag = slot_i.buffer_data[F_T_REG];
            if (slot_i.buffer_data[F_T_IND]) begin
              c.indirect_pending_flag = 1'b1;
              c.state_class = CLS_TWO;
              c.step = STEP_ONE;
            end else begin
              c.indirect_pending_flag = 1'b0;
              {c.state_class, c.step} = start_state(c.instruction_register[F_OP_HI:F_OP_LO]);
            end
          end
        end
        default: begin
          c.state_class = CLS_EXEC;
          c.step = STEP_EXEC;
        end
      endcase

      if (term) begin
        if ((slot_i.auto_int || slot_i.prog_int) && !c.interrupt_active_flag &&
            c.instruction_register[F_OP_HI:F_OP_LO] != OP_EXECUTE_MEMORY_OP) begin
          c.interrupt_active_flag = 1'b1;
          c.memory_source_flag = 1'b1;
          c.int_auto = slot_i.auto_int;
          c.instruction_register[F_OP_HI:F_OP_LO] = OP_NOOP;
          c.pc = c.pc + PC_STEP;
          c.state_class = CLS_TWO;
          c.step = STEP_THREE;
        end else begin
          word = from_buf ? slot_i.buffer_data : c.next_instruction_hold;
          next_st.pipe.advance = 1'b1;
          next_st.pipe.from_buffer = from_buf;
          next_st.pipe.vp = slot_i.vp;
          if (clear_int) begin
            c.interrupt_active_flag = 1'b0;
            c.rom_origin = 1'b1;
          end
          c.instruction_register = word;
          c.ea = word[F_N_HI:F_N_LO];
          c.cell_in_register_flag = word[F_T_REG];
          if (word[F_T_IND] && !slot_i.ignore_indirection &&
              word[F_OP_HI:F_OP_HI-3] != CBR_GROUP) begin
            c.indirect_pending_flag = 1'b1;
            c.state_class = CLS_TWO;
            c.step = STEP_ONE;
          end else begin
            c.indirect_pending_flag = 1'b0;
            c.memory_source_flag = c.rom_origin;
            {c.state_class, c.step} = start_state(word[F_OP_HI:F_OP_LO]);
          end
        end
      end
      next_st.ctx[slot_i.vp] = c;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0;
      st.run <= RUN_RESET;
      for (int i = 0; i < NUM_VP; i++) begin
        st.ctx[i].state_class <= CLS_EXEC;
        st.ctx[i].step <= STEP_EXEC;
      end
    end else begin
      st <= next_st;
    end
  end

  default clocking dc @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  logic slot_go;
  vp_ctx_type cur;
  assign slot_go = st.run && slot_i.valid;
  assign cur = st.ctx[slot_i.vp];

  int_entry_a: assert property (
    slot_go && {cur.state_class, cur.step} == {CLS_EXEC, STEP_EXEC} &&
    (cur.instruction_register[F_OP_HI:F_OP_LO] == OP_NOOP ? (cur.rom_origin || slot_i.buffer_avail) :
      slot_i.instruction_done_signal) &&
    cur.instruction_register[F_OP_HI:F_OP_LO] != OP_EXECUTE_MEMORY_OP &&
    (slot_i.auto_int || slot_i.prog_int) && !cur.interrupt_active_flag
    |=> st.ctx[$past(slot_i.vp)].interrupt_active_flag && st.ctx[$past(slot_i.vp)].step == STEP_THREE &&
        st.ctx[$past(slot_i.vp)].int_auto == $past(slot_i.auto_int) &&
        st.ctx[$past(slot_i.vp)].pc == $past(cur.pc) + PC_STEP && !st.pipe.advance)
    else $error("interrupt entry not taken");

  int_vector_a: assert property (
    slot_go && {cur.state_class, cur.step} == {CLS_TWO, STEP_THREE}
    |=> st.ctx[$past(slot_i.vp)].next_instruction_hold[15:0] == ($past(cur.int_auto) ? VEC_AUTO : VEC_PROG) &&
        st.ctx[$past(slot_i.vp)].pc == $past(cur.pc) - PC_BACK &&
        st.ctx[$past(slot_i.vp)].state_class == CLS_THREE)
    else $error("interrupt vector or pc wrong");

  int_done_a: assert property (
    slot_go && cur.interrupt_active_flag && {cur.state_class, cur.step} == {CLS_THREE, STEP_TWO} &&
    slot_i.buffer_avail
    |=> st.pipe.advance && !st.ctx[$past(slot_i.vp)].interrupt_active_flag)
    else $error("interrupt exit missing");

  ind_pending_a: assert property (
    st.pipe.advance |-> st.ctx[st.pipe.vp].indirect_pending_flag ==
      ({st.ctx[st.pipe.vp].state_class, st.ctx[st.pipe.vp].step} == {CLS_TWO, STEP_ONE}))
    else $error("pending flag disagrees with state");

  read_issue_a: assert property (
    st.cmd.read_req |-> st.cmd.read_addr == st.ctx[st.cmd.vp].ea &&
      {st.ctx[st.cmd.vp].state_class, st.ctx[st.cmd.vp].step} == {CLS_TWO, STEP_TWO})
    else $error("read request address or state wrong");

  rom_no_save_a: assert property (
    slot_go && {cur.state_class, cur.step} == {CLS_TWO, STEP_ONE} && cur.rom_origin
    |=> st.ctx[$past(slot_i.vp)].next_instruction_hold == $past(cur.next_instruction_hold) &&
        st.ctx[$past(slot_i.vp)].memory_source_flag == $past(cur.memory_source_flag))
    else $error("rom indirect saved buffer data");

  noop_wait_a: assert property (
    slot_go && {cur.state_class, cur.step} == {CLS_EXEC, STEP_EXEC} && !cur.rom_origin &&
    cur.instruction_register[F_OP_HI:F_OP_LO] == OP_NOOP && !slot_i.buffer_avail
    |=> !st.pipe.advance)
    else $error("memory no-op advanced without buffer");

  reg_copy_a: assert property (
    st.cmd.bd_copy |-> st.ctx[st.cmd.vp].cell_in_register_flag && !st.cmd.read_req)
    else $error("register copy outside register cell");

  slot_only_a: assert property (
    !slot_go |=> st.ctx == $past(st.ctx))
    else $error("context changed outside slot");

  apb_answer_a: assert property (
    apb_i.psel && apb_i.penable && !st.rsp.pready |=> st.rsp.pready ##1 !st.rsp.pready)
    else $error("apb answer timing wrong");

  cbr_bypass_a: assert property (
    st.pipe.advance && st.ctx[st.pipe.vp].instruction_register[F_OP_HI:F_OP_HI-3] == CBR_GROUP
    |-> !st.ctx[st.pipe.vp].indirect_pending_flag)
    else $error("branch took generic indirect cycle");

  rom_source_a: assert property (
    st.pipe.advance && st.ctx[st.pipe.vp].rom_origin && !st.ctx[st.pipe.vp].indirect_pending_flag
    |-> st.ctx[st.pipe.vp].memory_source_flag)
    else $error("rom instruction without source flag");

  lea_go_a: assert property (
    slot_go && {cur.state_class, cur.step} == {CLS_LEA, STEP_LEA} && slot_i.buffer_avail &&
    !slot_i.dependency && !slot_i.auto_int && !slot_i.prog_int
    |=> st.pipe.advance && st.pipe.from_buffer == !$past(cur.rom_origin))
    else $error("lea advance source wrong");

  lea_src_a: assert property (
    slot_go && {cur.state_class, cur.step} == {CLS_THREE, STEP_TWO} && !cur.interrupt_active_flag &&
    !slot_i.auto_int && !slot_i.prog_int
    |=> st.pipe.advance && st.pipe.from_buffer == !$past(cur.rom_origin))
    else $error("lea step two source wrong");

endmodule
`default_nettype wire

/* File: bench/buffer_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module buffer_partner import seq_pkg::*; #(
  parameter int LAT = 3
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire buf_cmd_type cmd_i,
  input wire logic stall_i,
  input wire logic [VP_W-1:0] vp_i,
  output logic avail_o,
  output logic [31:0] data_o
);
  logic [31:0] mem [0:255];
  logic [31:0] bd [NUM_VP];
  int cnt [NUM_VP];
  // read keeps the buffer busy for LAT cycles; register copy lands at once
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_VP; i++) begin
        cnt[i] <= 0;
      end
    end else begin
      for (int i = 0; i < NUM_VP; i++) begin
        if (cnt[i] > 0) begin
          cnt[i] <= cnt[i] - 1;
        end
      end
      if (cmd_i.read_req) begin
        cnt[cmd_i.vp] <= LAT;
        bd[cmd_i.vp] <= mem[cmd_i.read_addr[7:0]];
      end
      if (cmd_i.bd_copy) begin
        bd[cmd_i.vp] <= {24'h00_0001, 2'b00, cmd_i.reg_sel};
      end
    end
  end
  // a read just issued makes the buffer busy at once
  assign avail_o = (cnt[vp_i] == 0) && !stall_i && !(cmd_i.read_req && cmd_i.vp == vp_i);
  // busy buffer shows junk rather than the last word
  assign data_o = avail_o ? bd[vp_i] : ~bd[vp_i];
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top import seq_pkg::*; ;
  localparam logic [31:0] M9 = 32'h0000_01FF;
  localparam logic [31:0] M10 = 32'h0000_03FF;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic stall = 1'b0;
  apb_req_type req = '0;
  apb_rsp_type rsp;
  slot_type slot = '0;
  slot_type sl_in;
  buf_cmd_type cmd;
  pipe_evt_type pipe;
  logic avail;
  logic [31:0] bdata;
  logic [31:0] q;
  logic err;
  logic [3:0] s;
  int fails = 0;
  int n_tests = 0;

  always #2 mclk_i = ~mclk_i;
  always_comb begin
    sl_in = slot;
    sl_in.buffer_avail = avail;
    sl_in.buffer_data = bdata;
  end

  indirect_and_interrupt_sequencer u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .apb_i(req), .apb_o(rsp),
    .slot_i(sl_in), .cmd_o(cmd), .pipe_o(pipe));
  buffer_partner #(.LAT(3)) u_buf (.mclk_i(mclk_i), .rst_i(rst_i), .cmd_i(cmd), .stall_i(stall),
    .vp_i(slot.vp), .avail_o(avail), .data_o(bdata));

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", n, e, g);
      fails++;
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge mclk_i);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge mclk_i);
    req.penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge mclk_i);
      if (rsp.pready === 1'b1) break;
    end
    if (i == 20) begin
      chk("pready", 32'h0000_0001, 32'h0000_0000);
      final_report();
    end
    q = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk("register", e, q & m);
  endtask

  task automatic st(input int vp, input logic [31:0] m, input logic [31:0] e);
    apb(1'b1, OFF_VPSEL, vp);
    rd(OFF_STATUS, m, e);
  endtask

  // f is {done, dependency, ignore, auto, programmed}
  task automatic sl(input int vp, input logic [4:0] f, output logic [3:0] seen);
    @(posedge mclk_i);
    slot <= '{1'b1, VP_W'(vp), 1'b0, 32'h0000_0000, f[4], f[3], f[2], f[1], f[0]};
    @(posedge mclk_i);
    slot.valid <= 1'b0;
    #1;
    seen = {pipe.advance, pipe.advance & pipe.from_buffer, cmd.read_req, cmd.bd_copy};
  endtask

  task automatic wa();
    int i;
    for (i = 0; i < 20; i++) begin
      @(posedge mclk_i);
      #1;
      if (avail === 1'b1) break;
    end
    if (i == 20) begin
      chk("avail", 32'h0000_0001, 32'h0000_0000);
      final_report();
    end
  endtask

  task automatic t_reset();
    rd(OFF_CTRL, ALL, 32'h0000_0001);
    rd(OFF_STATUS, ALL, 32'h0000_0011);
    apb(1'b0, 12'h014, 32'h0000_0000);
    chk("pslverr", 32'h0000_0001, {31'h0000_0000, err});
    $display("test reset done");
  endtask

  task automatic t_int();
    sl(0, 5'h12, s);
    chk("pipe", 32'h0000_0000, {28'h000_0000, s});
    st(0, ALL, 32'h0000_0623);
    rd(OFF_PC, ALL, 32'h0000_0001);
    sl(0, 5'h00, s);
    st(0, ALL, 32'h0000_0632);
    rd(OFF_PC, ALL, 32'h0000_FFFF);
    sl(0, 5'h00, s);
    chk("pipe", 32'h0000_0008, {28'h000_0000, s});
    rd(OFF_IR, ALL, 32'h0000_0010);
    st(0, ALL, 32'h0000_0A11);
    @(posedge mclk_i) stall <= 1'b1;
    sl(0, 5'h00, s);
    chk("pipe", 32'h0000_0008, {28'h000_0000, s});
    @(posedge mclk_i) stall <= 1'b0;
    sl(1, 5'h11, s);
    sl(1, 5'h00, s);
    sl(1, 5'h00, s);
    apb(1'b1, OFF_VPSEL, 32'h0000_0001);
    rd(OFF_IR, ALL, 32'h0000_0011);
    $display("test interrupt done");
  endtask

  task automatic t_ind();
    u_buf.mem[8'h40] = 32'h0008_0050;
    u_buf.mem[8'h50] = 32'h0000_0077;
    u_buf.bd[2] = 32'h1008_0040;
    @(posedge mclk_i) stall <= 1'b1;
    sl(2, 5'h00, s);
    chk("pipe", 32'h0000_0000, {28'h000_0000, s});
    @(posedge mclk_i) stall <= 1'b0;
    sl(2, 5'h00, s);
    chk("pipe", 32'h0000_000C, {28'h000_0000, s});
    st(2, M9, 32'h0000_0121);
    sl(2, 5'h00, s);
    chk("cmd", 32'h0000_0002, {28'h000_0000, s});
    chk("addr", 32'h0000_0040, {16'h0000, cmd.read_addr});
    chk("cmd vp", 32'h0000_0002, {29'h0000_0000, cmd.vp});
    st(2, M10, 32'h0000_0322);
    wa();
    sl(2, 5'h00, s);
    st(2, M9, 32'h0000_0121);
    sl(2, 5'h00, s);
    chk("addr", 32'h0000_0050, {16'h0000, cmd.read_addr});
    sl(2, 5'h00, s);
    st(2, M9, 32'h0000_0122);
    wa();
    sl(2, 5'h00, s);
    st(2, M9, 32'h0000_0011);
    $display("test indirect done");
  endtask

  task automatic t_reg();
    u_buf.bd[3] = 32'h410C_0143;
    sl(3, 5'h00, s);
    sl(3, 5'h00, s);
    chk("cmd", 32'h0000_0001, {28'h000_0000, s});
    chk("reg_sel", 32'h0000_0005, {26'h000_0000, cmd.reg_sel});
    sl(3, 5'h00, s);
    st(3, M9, 32'h0000_0011);
    sl(3, 5'h14, s);
    chk("pipe", 32'h0000_0008, {28'h000_0000, s});
    st(3, M10, 32'h0000_0011);
    u_buf.bd[5] = 32'h5008_0040;
    sl(5, 5'h00, s);
    st(5, M9, 32'h0000_0011);
    u_buf.bd[4] = 32'h2100_0000;
    sl(4, 5'h00, s);
    chk("pipe vp", 32'h0000_0004, {29'h0000_0000, pipe.vp});
    st(4, M9, 32'h0000_0072);
    sl(4, 5'h08, s);
    chk("pipe", 32'h0000_0000, {28'h000_0000, s});
    st(4, M9, 32'h0000_0032);
    sl(4, 5'h00, s);
    chk("pipe", 32'h0000_000C, {28'h000_0000, s});
    sl(4, 5'h00, s);
    chk("pipe", 32'h0000_000C, {28'h000_0000, s});
    apb(1'b1, OFF_CTRL, 32'h0000_0000);
    sl(4, 5'h10, s);
    chk("pipe", 32'h0000_0000, {28'h000_0000, s});
    apb(1'b1, OFF_CTRL, 32'h0000_0001);
    st(4, M9, 32'h0000_0072);
    $display("test register cell and lea done");
  endtask

  initial begin
    repeat (5) @(posedge mclk_i);
    rst_i <= 1'b0;
    t_reset();
    t_int();
    t_ind();
    t_reg();
    final_report();
  end
endmodule
`default_nettype wire
